// ==== trafo_pkg.sv ====
// Purpose: Shared types and constants for the transformer bay isolation and reclose logic
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   Travel time is a supervision window, not a plant figure
`default_nettype none

package trafo_pkg;

    // Two-contact disconnector position as it arrives from the plant
    typedef struct packed {
        logic open_c;
        logic closed_c;
    } pos_t;

    // Decoded position shown to the other corner modules
    typedef struct packed {
        logic is_open;
        logic is_closed;
        logic position_discrepancy;
    } ind_t;

    // Reclose outputs towards the mesh and low side reclose modules
    typedef struct packed {
        logic start_high_side_reclose;
        logic lockout_high_side_reclose;
        logic lockout_low_side_reclose;
    } reclose_t;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h1,
        S_OPEN  = 4'h2,
        S_START = 4'h4,
        S_LOCK  = 4'h8
    } seq_t;

    localparam logic [1:0] POS_OPEN   = 2'h2;
    localparam logic [1:0] POS_CLOSED = 2'h1;
    localparam int         SYNC_W     = 4;

    localparam int CLK_HZ         = 25_000_000;
    localparam int MS_PER_S       = 1000;
    localparam int TRAVEL_TIME_MS = 200;
    // Longest wait for the disconnector to report open, rounded down
    localparam int TRAVEL_CYCLES  = TRAVEL_TIME_MS * (CLK_HZ / MS_PER_S);

    localparam ind_t     IND_RESET     = 3'h0;
    localparam reclose_t RECLOSE_RESET = 3'h0;

endpackage : trafo_pkg

`default_nettype wire

// ==== pin_sync.sv ====
// Purpose: Two-flop synchroniser for plant status pins
// Assumes: Pins are slow levels; no multi-bit coherence is needed
// Notes:   Only the second stage is visible outside
`default_nettype none

module pin_sync #(
    parameter int W = 4
) (
    // Clocking
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : pin_sync

`default_nettype wire

// ==== position_monitor.sv ====
// Purpose: Decodes the two-contact disconnector position into indications
// Assumes: Input already synchronised to clk
// Notes:   Both contacts equal counts as a discrepancy
`default_nettype none

module position_monitor
    import trafo_pkg::*;
(
    // Clocking
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Position
    input  wire pos_t pos,
    output ind_t      ind
);

    function automatic ind_t decode(input pos_t p);
        ind_t r;
        r.is_open              = (p == POS_OPEN);
        r.is_closed            = (p == POS_CLOSED);
        r.position_discrepancy = (p.open_c == p.closed_c);
        return r;
    endfunction : decode

    always_ff @(posedge clk) begin
        if (rst) begin
            ind <= IND_RESET;
        end else if (ce) begin
            ind <= decode(pos); // R3 R12
        end
    end

    property p_discrepancy;
        @(posedge clk) disable iff (rst)
        (ce && pos.open_c == pos.closed_c) |=> ind.position_discrepancy && !ind.is_open;
    endproperty
    a_discrepancy: assert property (p_discrepancy) else $error("discrepancy not flagged"); // R12

    property p_open_decode;
        @(posedge clk) disable iff (rst)
        (ce && pos == POS_OPEN) |=> ind.is_open && !ind.is_closed;
    endproperty
    a_open_decode: assert property (p_open_decode) else $error("open position not shown"); // R3

endmodule : position_monitor

`default_nettype wire

// ==== transformer_isolation_reclose_logic.sv ====
// Purpose: Isolation and reclose control for one transformer bay at a mesh corner
// Assumes: Supervisor and reclose signals share MCLK; plant contacts are asynchronous
// Notes:   Reclose outputs are one-cycle pulses; commands are levels
`default_nettype none

// What this block does
// R1: Two states, healthy and faulty; fault input forces faulty.
// R2: While faulty, position is still shown but no switching command is issued.
// R3: Disconnector position reported as separate open and closed indications.
// R4: Invalid two-contact combination raises the disconnector status alarm.
// R5: Supervisor sends repeated enable and disable controls selecting the mode.
// R6: Auto-switching and reclose both disabled: protection initiations are ignored.
// R7: Auto-switching only: isolate on trip, never start a reclose.
// R8: Both enabled: isolation and reclose depend on trigger and plant position.
// R9: No-reclose trip, closed: open disconnector, start mesh reclose, lock out low side.
// R10: No-reclose trip, already open: lock out mesh and low side reclose.
// R11: Isolator is never operated while the corner is live.
// R12: Discrepancy means both contacts set or both clear.
// R13: Other-module requests drive plant commands only if healthy, enabled, not inhibited.
// R14: Healthy output is high exactly while in the healthy state.
module transformer_isolation_reclose_logic
    import trafo_pkg::*;
#(
    parameter int TRAVEL_LIMIT = TRAVEL_CYCLES
) (
    // Clocking
    input  wire logic MCLK,
    input  wire logic SYS_RST,
    input  wire logic CE,
    // Plant status pins
    input  wire pos_t DISC_POS,
    input  wire logic DISC_INHIBIT,
    input  wire logic TRIP_WITHOUT_RECLOSE,
    // Supervisor and neighbours
    input  wire logic AUTO_SW_ON,
    input  wire logic AUTO_SW_OFF,
    input  wire logic RECLOSE_ON,
    input  wire logic RECLOSE_OFF,
    input  wire logic OPEN_REQ,
    input  wire logic CLOSE_REQ,
    input  wire logic LIVE_LINE,
    input  wire logic RECLAIM_RUNNING,
    input  wire logic FUNCTION_FAULT,
    // Plant commands
    output logic      OPEN_CMD,
    output logic      CLOSE_CMD,
    // Indications
    output ind_t      DISC_IND,
    output logic      DISC_ALARM,
    output logic      DISC_FAIL,
    output logic      AUTO_SW_ACTIVE,
    output logic      HEALTHY,
    // Reclose module pulses
    output reclose_t  RECLOSE
);

    localparam int TW = $clog2(TRAVEL_LIMIT + 1);

    logic [SYNC_W-1:0] sync_q;
    pos_t              pos_s;
    logic              inhibit_s;
    logic              trip_s;
    logic              trip_q;
    logic              trip_edge;
    ind_t              ind;
    logic              healthy;
    logic              auto_sw;
    logic              dar_on;
    logic              armed;
    logic              switch_ok;
    seq_t              state;
    seq_t              next_state;
    logic [TW-1:0]     travel;
    logic              travel_done;

    pin_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk (MCLK),
        .rst (SYS_RST),
        .ce  (CE),
        .d   ({DISC_POS, DISC_INHIBIT, TRIP_WITHOUT_RECLOSE}),
        .q   (sync_q)
    );

    assign pos_s     = sync_q[3:2];
    assign inhibit_s = sync_q[1];
    assign trip_s    = sync_q[0];

    position_monitor u_pos (
        .clk (MCLK),
        .rst (SYS_RST),
        .ce  (CE),
        .pos (pos_s),
        .ind (ind)
    );

    assign DISC_IND   = ind;                        // R3
    assign DISC_ALARM = ind.position_discrepancy;   // R4
    assign HEALTHY    = healthy;                    // R14
    assign AUTO_SW_ACTIVE = (state != S_IDLE);

    // Health follows the fault input; recovery needs the fault to clear
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            healthy <= 1'b1;
        end else if (CE) begin
            healthy <= !FUNCTION_FAULT; // R1 R14
        end
    end

    // Disable wins over enable so a confused supervisor fails safe
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            auto_sw <= 1'b0;
            dar_on  <= 1'b0;
        end else if (CE) begin
            if (AUTO_SW_OFF) begin
                auto_sw <= 1'b0;
            end else if (AUTO_SW_ON) begin
                auto_sw <= 1'b1;
            end
            if (RECLOSE_OFF) begin
                dar_on <= 1'b0;
            end else if (RECLOSE_ON) begin
                dar_on <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            trip_q <= 1'b0;
        end else if (CE) begin
            trip_q <= trip_s;
        end
    end

    assign trip_edge = trip_s && !trip_q;
    assign armed     = healthy && auto_sw;                          // R6
    // Common gate for any isolator movement
    assign switch_ok = healthy && auto_sw && !inhibit_s && !LIVE_LINE; // R2 R11 R13

    // Reclaim timer state does not change the action for this trigger
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (trip_edge && armed) begin
                    if (ind.is_closed) begin
                        next_state = S_OPEN;  // R9
                    end else begin
                        next_state = S_LOCK;  // R10
                    end
                end
            end
            S_OPEN: begin
                if (!healthy) begin
                    next_state = S_IDLE;      // R2
                end else if (ind.is_open) begin
                    next_state = S_START;     // R9
                end else if (travel_done) begin
                    next_state = S_LOCK;
                end
            end
            S_START: next_state = S_IDLE;
            S_LOCK:  next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state <= S_IDLE;
        end else if (CE) begin
            state <= next_state;
        end
    end

    // Travel supervision: a live or inhibited corner also runs it out
    assign travel_done = (travel == TW'(TRAVEL_LIMIT));

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            travel <= '0;
        end else if (CE) begin
            if (state != S_OPEN) begin
                travel <= '0;
            end else if (!travel_done) begin
                travel <= travel + TW'(1);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            DISC_FAIL <= 1'b0;
        end else if (CE) begin
            if (state == S_OPEN && next_state == S_LOCK) begin
                DISC_FAIL <= 1'b1;
            end else if (trip_edge) begin
                DISC_FAIL <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            OPEN_CMD  <= 1'b0;
            CLOSE_CMD <= 1'b0;
        end else if (CE) begin
            OPEN_CMD  <= switch_ok && !ind.is_open
                         && ((state == S_OPEN) || (OPEN_REQ && !CLOSE_REQ)); // R9 R13
            CLOSE_CMD <= switch_ok && !ind.is_closed && (state == S_IDLE)
                         && CLOSE_REQ && !OPEN_REQ;                        // R13
        end
    end

    // Without reclose enabled the mesh start is withheld
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            RECLOSE <= RECLOSE_RESET;
        end else if (CE) begin
            RECLOSE.start_high_side_reclose   <= (state == S_START) && dar_on; // R7 R8 R9
            RECLOSE.lockout_low_side_reclose  <= (state == S_START)
                                                 || (state == S_LOCK);     // R9 R10
            RECLOSE.lockout_high_side_reclose <= (state == S_LOCK);        // R10
        end
    end

    property p_fault;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && FUNCTION_FAULT) |=> !HEALTHY;
    endproperty
    a_fault: assert property (p_fault) else $error("fault did not force faulty"); // R1

    property p_healthy;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && !FUNCTION_FAULT) |=> HEALTHY;
    endproperty
    a_healthy: assert property (p_healthy) else $error("healthy output wrong"); // R14

    property p_no_switch_faulty;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && !healthy) |=> !OPEN_CMD && !CLOSE_CMD;
    endproperty
    a_no_switch_faulty: assert property (p_no_switch_faulty) else $error("switching while faulty"); // R2

    property p_alarm;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && pos_s.open_c == pos_s.closed_c) |=> DISC_ALARM;
    endproperty
    a_alarm: assert property (p_alarm) else $error("status alarm missing"); // R4

    property p_ignore;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && !auto_sw && state == S_IDLE) |=> state == S_IDLE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("acted while disabled"); // R6

    property p_no_start;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && !dar_on) |=> !RECLOSE.start_high_side_reclose;
    endproperty
    a_no_start: assert property (p_no_start) else $error("reclose started while disabled"); // R7

    property p_start;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && state == S_START && dar_on) |=> RECLOSE.start_high_side_reclose
            && RECLOSE.lockout_low_side_reclose && !RECLOSE.lockout_high_side_reclose;
    endproperty
    a_start: assert property (p_start) else $error("start sequence wrong"); // R8

    property p_open_then_start;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && state == S_OPEN && healthy && ind.is_open) |=> state == S_START;
    endproperty
    a_open_then_start: assert property (p_open_then_start) else $error("no start after open"); // R9

    property p_lock_open;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && state == S_IDLE && trip_edge && armed && !ind.is_closed) |=> state == S_LOCK;
    endproperty
    a_lock_open: assert property (p_lock_open) else $error("no lockout when open"); // R10

    property p_live;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && LIVE_LINE) |=> !OPEN_CMD && !CLOSE_CMD;
    endproperty
    a_live: assert property (p_live) else $error("isolator moved while live"); // R11

    property p_req_gate;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && (inhibit_s || !auto_sw)) |=> !CLOSE_CMD && !OPEN_CMD;
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("request passed while blocked"); // R13

endmodule : transformer_isolation_reclose_logic

`default_nettype wire

// ==== disc_plant_model.sv ====
// Purpose: Behavioural disconnector with two position contacts
// Assumes: Commands are levels from the block; the bench may load a position
// Notes:   Both contacts drop while travelling, so mid-travel looks invalid
`default_nettype none

module disc_plant_model
    import trafo_pkg::*;
#(
    parameter int DELAY = 5
) (
    // Clocking
    input  wire logic clk,
    // Bench preset
    input  wire logic load,
    input  wire pos_t load_pos,
    // Plant commands
    input  wire logic open_cmd,
    input  wire logic close_cmd,
    // Contacts
    output pos_t      pos
);
    int travel;

    always_ff @(posedge clk) begin
        if (load) begin
            pos    <= load_pos;
            travel <= 0;
        end else if (open_cmd ^ close_cmd) begin
            if (travel == DELAY) begin
                pos <= open_cmd ? pos_t'(POS_OPEN) : pos_t'(POS_CLOSED);
            end else begin
                pos    <= pos_t'(2'h0);
                travel <= travel + 1;
            end
        end else begin
            // A conflicting or absent command leaves the mechanism where it is
            travel <= 0;
        end
    end
endmodule : disc_plant_model

`default_nettype wire

// ==== tb_transformer_isolation_reclose_logic.sv ====
// Purpose: Self-checking bench for the transformer bay isolation logic
// Assumes: Travel limit shortened to 20 cycles, plant travel 5 cycles
// Notes:   Inputs change on the falling edge; outputs sampled there too
`default_nettype none

module tb_transformer_isolation_reclose_logic
    import trafo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic     MCLK, SYS_RST, CE, DISC_INHIBIT, TRIP_WITHOUT_RECLOSE;
    logic     AUTO_SW_ON, AUTO_SW_OFF, RECLOSE_ON, RECLOSE_OFF;
    logic     OPEN_REQ, CLOSE_REQ, LIVE_LINE, RECLAIM_RUNNING, FUNCTION_FAULT;
    logic     OPEN_CMD, CLOSE_CMD, DISC_ALARM, DISC_FAIL, AUTO_SW_ACTIVE, HEALTHY;
    pos_t     DISC_POS, lp;
    ind_t     DISC_IND;
    reclose_t RECLOSE;
    logic     ld, acc_open, acc_close, acc_act;
    logic [2:0] acc_rec;
    int       err_total, samples_checked, n_pulse;

    transformer_isolation_reclose_logic #(.TRAVEL_LIMIT(20)) u_dut (
        .MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE), .DISC_POS(DISC_POS),
        .DISC_INHIBIT(DISC_INHIBIT), .TRIP_WITHOUT_RECLOSE(TRIP_WITHOUT_RECLOSE),
        .AUTO_SW_ON(AUTO_SW_ON), .AUTO_SW_OFF(AUTO_SW_OFF), .RECLOSE_ON(RECLOSE_ON),
        .RECLOSE_OFF(RECLOSE_OFF), .OPEN_REQ(OPEN_REQ), .CLOSE_REQ(CLOSE_REQ),
        .LIVE_LINE(LIVE_LINE), .RECLAIM_RUNNING(RECLAIM_RUNNING),
        .FUNCTION_FAULT(FUNCTION_FAULT), .OPEN_CMD(OPEN_CMD), .CLOSE_CMD(CLOSE_CMD),
        .DISC_IND(DISC_IND), .DISC_ALARM(DISC_ALARM), .DISC_FAIL(DISC_FAIL),
        .AUTO_SW_ACTIVE(AUTO_SW_ACTIVE), .HEALTHY(HEALTHY), .RECLOSE(RECLOSE));

    disc_plant_model #(.DELAY(5)) u_plant (
        .clk(MCLK), .load(ld), .load_pos(lp), .open_cmd(OPEN_CMD),
        .close_cmd(CLOSE_CMD), .pos(DISC_POS));

    always #20 MCLK = ~MCLK;

    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge MCLK);
    endtask : cyc

    task automatic set_pos(input logic [1:0] p);
        @(negedge MCLK);
        ld = 1'b1;
        lp = pos_t'(p);
        @(negedge MCLK);
        ld = 1'b0;
        cyc(5);
    endtask : set_pos

    task automatic set_modes(input logic as_on, input logic rc_on);
        @(negedge MCLK);
        AUTO_SW_ON  = as_on;
        AUTO_SW_OFF = !as_on;
        RECLOSE_ON  = rc_on;
        RECLOSE_OFF = !rc_on;
        @(negedge MCLK);
        {AUTO_SW_ON, AUTO_SW_OFF, RECLOSE_ON, RECLOSE_OFF} = 4'h0;
    endtask : set_modes

    // Collects every command and reclose pulse seen over a window
    task automatic watch(input int n);
        {acc_open, acc_close, acc_act, acc_rec} = 6'h00;
        n_pulse = 0;
        repeat (n) begin
            @(negedge MCLK);
            acc_open  |= OPEN_CMD;
            acc_close |= CLOSE_CMD;
            acc_act   |= AUTO_SW_ACTIVE;
            acc_rec   |= RECLOSE;
            if (RECLOSE !== 3'h0) n_pulse++;
        end
    endtask : watch

    task automatic trip_run();
        @(negedge MCLK);
        TRIP_WITHOUT_RECLOSE = 1'b1;
        watch(40);
        TRIP_WITHOUT_RECLOSE = 1'b0;
        cyc(6);
    endtask : trip_run

    task automatic test_end(input string name);
        $display("test %s done, errors %0d", name, err_total);
    endtask : test_end

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge MCLK);
        err_total++;
        final_report();
    end

    initial begin
        MCLK = 1'b0;
        SYS_RST = 1'b1;
        CE = 1'b1;
        {DISC_INHIBIT, TRIP_WITHOUT_RECLOSE, AUTO_SW_ON, AUTO_SW_OFF} = 4'h0;
        {RECLOSE_ON, RECLOSE_OFF, OPEN_REQ, CLOSE_REQ} = 4'h0;
        // Plant loads closed during reset so its contacts never show unknowns
        {LIVE_LINE, RECLAIM_RUNNING, FUNCTION_FAULT, ld} = 4'h1;
        lp = pos_t'(POS_CLOSED);
        err_total = 0;
        samples_checked = 0;
        cyc(2);
        SYS_RST = 1'b0;
        ld = 1'b0;
        chk("healthy", {3'h0, HEALTHY}, 4'h1);
        chk("commands", {2'h0, OPEN_CMD, CLOSE_CMD}, 4'h0);
        test_end("reset");
        for (int i = 0; i < 4; i++) begin
            set_pos(i[1:0]);
            chk("indication", {1'b0, DISC_IND},
                (i == 2) ? 4'h4 : (i == 1) ? 4'h2 : 4'h1);
            chk("alarm", {3'h0, DISC_ALARM}, (i == 0 || i == 3) ? 4'h1 : 4'h0);
        end
        test_end("position");
        set_pos(POS_CLOSED);
        trip_run();
        chk("disabled", {acc_open, acc_rec}, 4'h0);
        chk("disabled busy", {3'h0, acc_act}, 4'h0);
        test_end("disabled");
        set_modes(1'b1, 1'b1);
        for (int r = 0; r < 2; r++) begin
            RECLAIM_RUNNING = r[0];
            set_pos(POS_CLOSED);
            trip_run();
            chk("trip closed cmd", {3'h0, acc_open}, 4'h1);
            chk("trip closed pulse", {1'b0, acc_rec}, 4'h5);
            chk("pulse width", n_pulse[3:0], 4'h1);
            chk("now open", {1'b0, DISC_IND}, 4'h4);
            set_pos(POS_OPEN);
            trip_run();
            chk("trip open cmd", {3'h0, acc_open}, 4'h0);
            chk("trip open pulse", {1'b0, acc_rec}, 4'h3);
        end
        RECLAIM_RUNNING = 1'b0;
        test_end("full");
        set_modes(1'b1, 1'b0);
        set_pos(POS_CLOSED);
        trip_run();
        chk("auto only cmd", {3'h0, acc_open}, 4'h1);
        chk("auto only pulse", {1'b0, acc_rec}, 4'h1);
        test_end("auto_only");
        set_pos(POS_CLOSED);
        LIVE_LINE = 1'b1;
        trip_run();
        chk("live cmd", {3'h0, acc_open}, 4'h0);
        chk("live pulse", {1'b0, acc_rec}, 4'h3);
        chk("travel fail", {3'h0, DISC_FAIL}, 4'h1);
        chk("live busy", {3'h0, acc_act}, 4'h1);
        OPEN_REQ = 1'b1;
        watch(15);
        chk("live request", {2'h0, acc_open, acc_close}, 4'h0);
        OPEN_REQ = 1'b0;
        LIVE_LINE = 1'b0;
        test_end("live");
        FUNCTION_FAULT = 1'b1;
        cyc(3);
        chk("faulty", {3'h0, HEALTHY}, 4'h0);
        set_pos(2'h3);
        chk("faulty alarm", {3'h0, DISC_ALARM}, 4'h1);
        set_pos(POS_CLOSED);
        OPEN_REQ = 1'b1;
        trip_run();
        chk("faulty cmd", {acc_open, acc_rec}, 4'h0);
        OPEN_REQ = 1'b0;
        FUNCTION_FAULT = 1'b0;
        cyc(3);
        chk("healthy again", {3'h0, HEALTHY}, 4'h1);
        test_end("fault");
        OPEN_REQ = 1'b1;
        watch(25);
        chk("open req", {3'h0, acc_open}, 4'h1);
        chk("opened", {1'b0, DISC_IND}, 4'h4);
        OPEN_REQ = 1'b0;
        CLOSE_REQ = 1'b1;
        watch(25);
        chk("close req", {3'h0, acc_close}, 4'h1);
        chk("closed", {1'b0, DISC_IND}, 4'h2);
        CLOSE_REQ = 1'b0;
        DISC_INHIBIT = 1'b1;
        // Inhibit pin needs its two sync stages before the request arrives
        cyc(3);
        OPEN_REQ = 1'b1;
        watch(15);
        chk("inhibited", {3'h0, acc_open}, 4'h0);
        DISC_INHIBIT = 1'b0;
        CLOSE_REQ = 1'b1;
        watch(15);
        chk("both requests", {2'h0, acc_open, acc_close}, 4'h0);
        {OPEN_REQ, CLOSE_REQ} = 2'h0;
        set_modes(1'b0, 1'b0);
        OPEN_REQ = 1'b1;
        watch(15);
        chk("auto off", {3'h0, acc_open}, 4'h0);
        OPEN_REQ = 1'b0;
        test_end("requests");
        final_report();
    end
endmodule : tb_transformer_isolation_reclose_logic

`default_nettype wire
